// >>> hdl/vdc_host.sv
`timescale 1ns/10ps
// Overview of operation
// - After a read transfer, give at least two shift clocks before using data.
// - A row written by transfer must be refreshed within 4 ms.
// - At least 256 shift clocks every 4 ms, in either direction.
// - For real-time transfer, keep shifting and place xfer_oe_n rise in window.
// - Refresh all 256 rows at least once every 4 ms.
module vdc_host (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Command port
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire logic [2:0]                  cmd_op,
  input  wire logic [vdc_pkg::ADDR_W-1:0]  cmd_row,
  input  wire logic [vdc_pkg::ADDR_W-1:0]  cmd_col,
  input  wire logic [vdc_pkg::WORD_W-1:0]  cmd_data,
  input  wire logic                        cmd_mask_en,
  input  wire logic [vdc_pkg::WORD_W-1:0]  cmd_mask,
  // Array read answer
  output logic                             rd_valid,
  output logic [vdc_pkg::WORD_W-1:0]       rd_data,
  // Serial read stream
  input  wire logic                        stream_en,
  output logic                             out_valid,
  output logic [vdc_pkg::WORD_W-1:0]       out_data,
  input  wire logic                        out_ready,
  // Serial write source
  input  wire logic                        ser_in_valid,
  input  wire logic [vdc_pkg::WORD_W-1:0]  ser_in_data,
  output logic                             ser_in_ready,
  output logic                             serial_is_input,
  // Array port pins
  output logic                             row_strobe_n,
  output logic                             column_strobe_n,
  output logic                             mask_write_n,
  output logic                             xfer_oe_n,
  output logic [vdc_pkg::ADDR_W-1:0]       addr_in,
  input  wire logic [vdc_pkg::WORD_W-1:0]  mask_dq_i,
  output logic [vdc_pkg::WORD_W-1:0]       mask_dq_o,
  output logic                             mask_dq_oe,
  // Serial port pins
  output logic                             serial_shift_clk,
  output logic                             serial_enable_n,
  input  wire logic [vdc_pkg::WORD_W-1:0]  serial_data_i,
  output logic [vdc_pkg::WORD_W-1:0]       serial_data_o,
  output logic                             serial_data_oe
);

  vdc_pkg::vdc_state_t          state;
  vdc_pkg::vdc_op_t             op_q;
  logic [2:0]                   cnt;
  logic [vdc_pkg::ADDR_W-1:0]   col_q;
  logic [vdc_pkg::WORD_W-1:0]   data_q;
  logic                         xfer_load;
  logic [vdc_pkg::WORD_W-1:0]   dq_s1, dq_s2, sd_s1, sd_s2;
  logic [8:0]                   ref_cnt;
  logic                         ref_pend;
  logic                         ref_start;
  logic                         sh_act;
  logic [1:0]                   sh_ph;
  logic                         sh_data;
  logic [1:0]                   dummy_left;
  logic [8:0]                   keep_cnt;
  logic                         busy_block;
  logic                         want_shift;
  logic                         fifo_ready;
  logic                         fifo_push;

  function automatic logic is_xfer(input vdc_pkg::vdc_op_t op);
    return (op == vdc_pkg::OP_RD_XFER) || (op == vdc_pkg::OP_WR_XFER) ||
           (op == vdc_pkg::OP_PSEUDO) || (op == vdc_pkg::OP_RT_XFER);
  endfunction

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      sd_s1 <= '0;
      sd_s2 <= '0;
    end else begin
      dq_s1 <= mask_dq_i;
      dq_s2 <= dq_s1;
      sd_s1 <= serial_data_i;
      sd_s2 <= sd_s1;
    end
  end

  // One row every interval walks all rows just inside the refresh period, which also
  // covers rows written by transfer.
  assign ref_start = (state == vdc_pkg::ST_IDLE) && ref_pend && !(cmd_valid && cmd_ready);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt  <= '0;
      ref_pend <= 1'b0;
    end else begin
      if (ref_cnt == vdc_pkg::REF_INT - 9'h1) begin
        ref_cnt  <= '0;
        ref_pend <= 1'b1;
      end else begin
        ref_cnt <= ref_cnt + 9'h1;
        if (ref_start) begin
          ref_pend <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state           <= vdc_pkg::ST_IDLE;
      op_q            <= vdc_pkg::OP_READ;
      cnt             <= '0;
      col_q           <= '0;
      data_q          <= '0;
      cmd_ready       <= 1'b0;
      rd_valid        <= 1'b0;
      rd_data         <= '0;
      row_strobe_n    <= 1'b1;
      column_strobe_n <= 1'b1;
      mask_write_n    <= 1'b1;
      xfer_oe_n       <= 1'b1;
      addr_in         <= '0;
      mask_dq_o       <= '0;
      mask_dq_oe      <= 1'b0;
      serial_is_input <= 1'b0;
      xfer_load       <= 1'b0;
    end else begin
      rd_valid  <= 1'b0;
      xfer_load <= 1'b0;
      unique case (state)
        vdc_pkg::ST_IDLE: begin
          mask_dq_oe <= 1'b0;
          if (cmd_valid && cmd_ready) begin
            op_q         <= vdc_pkg::vdc_op_t'(cmd_op);
            col_q        <= cmd_col;
            data_q       <= cmd_data;
            cmd_ready    <= 1'b0;
            addr_in      <= cmd_row;
            xfer_oe_n    <= !is_xfer(vdc_pkg::vdc_op_t'(cmd_op));
            mask_write_n <= !((cmd_op == vdc_pkg::OP_WRITE && cmd_mask_en) ||
                              cmd_op == vdc_pkg::OP_WR_XFER ||
                              cmd_op == vdc_pkg::OP_PSEUDO);
            mask_dq_o    <= cmd_mask;
            mask_dq_oe   <= (cmd_op == vdc_pkg::OP_WRITE) && cmd_mask_en;
            state        <= vdc_pkg::ST_ROW;
            cnt          <= 3'h1;
          end else if (ref_start) begin
            op_q            <= vdc_pkg::OP_REFRESH;
            cmd_ready       <= 1'b0;
            column_strobe_n <= 1'b0;
            state           <= vdc_pkg::ST_ROW;
            cnt             <= vdc_pkg::FCS_CYC;
          end else begin
            cmd_ready <= 1'b1;
          end
        end
        vdc_pkg::ST_ROW: begin
          if (cnt != 3'h1) begin
            cnt <= cnt - 3'h1;
          end else if (!is_xfer(op_q) || op_q == vdc_pkg::OP_RT_XFER ||
                       (!sh_act && serial_enable_n == (op_q != vdc_pkg::OP_WR_XFER))) begin
            row_strobe_n <= 1'b0;
            state        <= vdc_pkg::ST_RAS;
            cnt          <= (op_q == vdc_pkg::OP_REFRESH) ? vdc_pkg::RAS_CYC : vdc_pkg::RAH_CYC;
            if (is_xfer(op_q)) begin
              // Read kinds turn the port to output, write kinds to input.
              serial_is_input <= (op_q == vdc_pkg::OP_WR_XFER) ||
                                 (op_q == vdc_pkg::OP_PSEUDO);
              xfer_load       <= (op_q == vdc_pkg::OP_RD_XFER);
            end
          end
        end
        vdc_pkg::ST_RAS: begin
          if (cnt != 3'h1) begin
            cnt <= cnt - 3'h1;
          end else if (op_q == vdc_pkg::OP_REFRESH) begin
            state <= vdc_pkg::ST_PRE;
          end else begin
            addr_in      <= col_q;
            mask_dq_o    <= data_q;
            mask_dq_oe   <= (op_q == vdc_pkg::OP_WRITE);
            mask_write_n <= (op_q != vdc_pkg::OP_WRITE);
            state        <= vdc_pkg::ST_COL;
            cnt          <= (op_q == vdc_pkg::OP_READ) ? vdc_pkg::RD_HOLD : vdc_pkg::WR_HOLD;
          end
        end
        vdc_pkg::ST_COL: begin
          if (column_strobe_n) begin
            column_strobe_n <= 1'b0;
            if (op_q == vdc_pkg::OP_READ) begin
              xfer_oe_n <= 1'b0;
            end
          end else if (cnt != 3'h1) begin
            cnt <= cnt - 3'h1;
          end else if (op_q != vdc_pkg::OP_RT_XFER || (sh_act && sh_ph == 2'h1)) begin
            // The real-time copy happens at this rise, just after a shift clock rise.
            xfer_oe_n    <= 1'b1;
            mask_write_n <= 1'b1;
            mask_dq_oe   <= 1'b0;
            state        <= vdc_pkg::ST_PRE;
            if (op_q == vdc_pkg::OP_READ) begin
              rd_valid <= 1'b1;
              rd_data  <= dq_s2;
            end
          end
        end
        vdc_pkg::ST_PRE: begin
          if (!row_strobe_n || !column_strobe_n) begin
            row_strobe_n    <= 1'b1;
            column_strobe_n <= 1'b1;
            cnt             <= vdc_pkg::RP_CYC;
          end else if (cnt == 3'h1) begin
            state <= vdc_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
      endcase
    end
  end

  // Shifting pauses during every array cycle except real-time transfers so the port direction never changes mid-cycle.
  assign busy_block = (state != vdc_pkg::ST_IDLE) && (op_q != vdc_pkg::OP_RT_XFER);
  assign want_shift = (dummy_left != 2'h0) || (keep_cnt >= vdc_pkg::SAM_KEEP - 9'h6) ||
                      (serial_is_input ? ser_in_valid : (stream_en && fifo_ready));
  assign fifo_push  = sh_act && (sh_ph == 2'h3) && sh_data && !serial_is_input;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_act           <= 1'b0;
      sh_ph            <= '0;
      sh_data          <= 1'b0;
      dummy_left       <= '0;
      keep_cnt         <= '0;
      serial_shift_clk <= 1'b0;
      serial_enable_n  <= 1'b1;
      serial_data_o    <= '0;
      serial_data_oe   <= 1'b0;
      ser_in_ready     <= 1'b0;
    end else begin
      ser_in_ready <= 1'b0;
      keep_cnt     <= (sh_act && sh_ph == 2'h0) ? 9'h0 : keep_cnt + 9'h1;
      if (xfer_load) begin
        dummy_left <= vdc_pkg::DUMMY_SH;
      end
      if (!sh_act) begin
        if (busy_block) begin
          serial_enable_n <= (op_q != vdc_pkg::OP_WR_XFER);
          serial_data_oe  <= 1'b0;
        end else if (want_shift) begin
          sh_act  <= 1'b1;
          sh_ph   <= 2'h0;
          sh_data <= (dummy_left == 2'h0) &&
                     (serial_is_input ? ser_in_valid : (stream_en && fifo_ready));
          // Dummy and keep-alive shifts run with the port disabled.
          serial_enable_n <= !((dummy_left == 2'h0) &&
                               (serial_is_input ? ser_in_valid
                                                : (stream_en && fifo_ready)));
          serial_data_o   <= ser_in_data;
          serial_data_oe  <= serial_is_input;
          ser_in_ready    <= serial_is_input && ser_in_valid && (dummy_left == 2'h0);
          if (dummy_left != 2'h0 && !xfer_load) begin
            dummy_left <= dummy_left - 2'h1;
          end
        end
      end else begin
        sh_ph <= sh_ph + 2'h1;
        unique case (sh_ph)
          2'h0: serial_shift_clk <= 1'b1;
          2'h2: serial_shift_clk <= 1'b0;
          2'h3: sh_act <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  vdc_fifo #(
    .W     (vdc_pkg::WORD_W),
    .DEPTH (vdc_pkg::FIFO_D)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_push),
    .in_data   (sd_s2),
    .in_ready  (fifo_ready),
    .out_valid (out_valid),
    .out_data  (out_data),
    .out_ready (out_ready)
  );

endmodule

// >>> hdl/vdc_pkg.sv
package vdc_pkg;

  localparam int CLK_NS = 50;

  // Least times round up to whole cycles, never below one.
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest times round down to whole cycles, never below one.
  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WORD_W   = 4;
  localparam int ADDR_W   = 8;
  localparam int FIFO_D   = 32;
  localparam int ROWS     = 256;
  localparam int SAM_WRDS = 256;

  localparam int T_RAS_NS  = 120;
  localparam int T_RP_NS   = 90;
  localparam int T_CAC_NS  = 60;
  localparam int T_FCS_NS  = 25;
  localparam int T_RAH_NS  = 12;
  localparam int T_SC_NS   = 40;
  localparam int T_REF_MS  = 4;
  localparam int SYNC_CYC  = 2;

  localparam logic [2:0] RAS_CYC  = 3'(cyc_min(T_RAS_NS));
  localparam logic [2:0] RP_CYC   = 3'(cyc_min(T_RP_NS));
  localparam logic [2:0] FCS_CYC  = 3'(cyc_min(T_FCS_NS));
  localparam logic [2:0] RAH_CYC  = 3'(cyc_min(T_RAH_NS));
  localparam logic [2:0] RD_HOLD  = 3'(cyc_min(T_CAC_NS) + SYNC_CYC + 1);
  localparam logic [2:0] WR_HOLD  = 3'(cyc_min(T_CAC_NS));
  localparam logic [8:0] REF_INT  = 9'(cyc_max(T_REF_MS * 1000000 / ROWS));
  localparam logic [8:0] SAM_KEEP = 9'(cyc_max(T_REF_MS * 1000000 / SAM_WRDS));
  localparam logic [1:0] DUMMY_SH = 2'h2;

  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_WRITE   = 3'h1,
    OP_RD_XFER = 3'h2,
    OP_WR_XFER = 3'h3,
    OP_PSEUDO  = 3'h4,
    OP_RT_XFER = 3'h5,
    OP_REFRESH = 3'h6
  } vdc_op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ROW  = 5'h02,
    ST_RAS  = 5'h04,
    ST_COL  = 5'h08,
    ST_PRE  = 5'h10
  } vdc_state_t;

endpackage

// >>> hdl/vdc_fifo.sv
`timescale 1ns/10ps
module vdc_fifo #(
  parameter int W     = 4,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (!out_valid || out_ready) && (count != '0);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // The output register keeps the drain side free of any path through the array.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (!out_valid || out_ready) begin
      out_valid <= (count != '0);
      if (count != '0) begin
        out_data <= mem[rd_ptr];
      end
    end
  end

endmodule

// >>> verif/vdc_host_props.sv
`timescale 1ns/10ps
module vdc_host_props (
  // Clock, reset, command port, read answer and direction flag
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [7:0] cmd_row,
  input wire logic [7:0] cmd_col,
  input wire logic       cmd_mask_en,
  input wire logic [3:0] cmd_mask,
  input wire logic       rd_valid,
  input wire logic       serial_is_input,
  // Device pins
  input wire logic       row_strobe_n,
  input wire logic       column_strobe_n,
  input wire logic       mask_write_n,
  input wire logic       xfer_oe_n,
  input wire logic [7:0] addr_in,
  input wire logic [3:0] mask_dq_o,
  input wire logic       mask_dq_oe,
  input wire logic       serial_shift_clk,
  input wire logic       serial_enable_n,
  input wire logic       serial_data_oe
);
  localparam int REF_MAX = 400;
  logic [2:0] op;
  logic [7:0] row;
  logic [7:0] col;
  logic [3:0] msk;
  logic       men;
  logic [1:0] dummies;
  logic [9:0] ref_gap;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) {op, row, col, msk, men} <= 24'h000000;
    else if (cmd_valid && cmd_ready) {op, row, col, msk, men} <=
      {cmd_op, cmd_row, cmd_col, cmd_mask, cmd_mask_en};
  end
  // Real-time transfers keep streaming, so only a plain read transfer restarts the count.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) dummies <= 2'h2;
    else if ($fell(row_strobe_n) && !xfer_oe_n && column_strobe_n && op == 3'h2) dummies <= 2'h0;
    else if ($rose(serial_shift_clk) && dummies != 2'h2) dummies <= dummies + 2'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) ref_gap <= 10'h000;
    else if ($fell(row_strobe_n) && !column_strobe_n) ref_gap <= 10'h000;
    else if (ref_gap != 10'h3ff) ref_gap <= ref_gap + 10'h001;
  end
  sequence s_shift_tail;
    serial_shift_clk ##1 !serial_shift_clk;
  endsequence
  sequence s_read_answer;
    ##[8:10] rd_valid;
  endsequence
  row_addr_a: assert property ($fell(row_strobe_n) && column_strobe_n |-> addr_in == row)
    else $error("row address differs from the accepted command");
  col_addr_a: assert property ($fell(column_strobe_n) && !row_strobe_n |-> addr_in == col)
    else $error("column address differs from the accepted command");
  cycle_kind_a: assert property ($fell(row_strobe_n) && column_strobe_n |->
    xfer_oe_n == (op < 3'h2) && mask_write_n == !(op == 3'h1 && men || op == 3'h3 || op == 3'h4))
    else $error("cycle kind pins wrong at row strobe");
  mask_bits_a: assert property ($fell(row_strobe_n) && column_strobe_n && op == 3'h1 && men
    |-> mask_dq_oe && mask_dq_o == msk) else $error("write mask not driven at row strobe");
  xfer_copy_a: assert property ($fell(row_strobe_n) && !xfer_oe_n && op != 3'h5
    |-> serial_enable_n == (op != 3'h3)) else $error("copy enable wrong in transfer");
  direction_a: assert property ($fell(row_strobe_n) && !xfer_oe_n |->
    ##[1:12] serial_is_input == (op == 3'h3 || op == 3'h4)) else $error("direction flag wrong");
  serial_drive_a: assert property (serial_data_oe |-> serial_is_input)
    else $error("serial data driven in read direction");
  dummy_shift_a: assert property ($rose(serial_shift_clk) && dummies != 2'h2 |-> serial_enable_n)
    else $error("serial output used before two shifts");
  shift_pulse_a: assert property ($rose(serial_shift_clk) |=> s_shift_tail)
    else $error("shift clock pulse shape wrong");
  read_answer_a: assert property (cmd_valid && cmd_ready && cmd_op == 3'h0 |-> s_read_answer)
    else $error("read answer missing");
  refresh_gap_a: assert property (ref_gap < REF_MAX)
    else $error("refresh interval too long");
endmodule
bind vdc_host vdc_host_props u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_row(cmd_row), .cmd_col(cmd_col), .cmd_mask_en(cmd_mask_en),
  .cmd_mask(cmd_mask), .rd_valid(rd_valid), .serial_is_input(serial_is_input),
  .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n), .mask_write_n(mask_write_n),
  .xfer_oe_n(xfer_oe_n), .addr_in(addr_in), .mask_dq_o(mask_dq_o), .mask_dq_oe(mask_dq_oe),
  .serial_shift_clk(serial_shift_clk), .serial_enable_n(serial_enable_n),
  .serial_data_oe(serial_data_oe));

// >>> verif/vdc_dev_model.sv
`timescale 1ns/10ps
module vdc_dev_model (
  // Array port
  input  wire logic       row_strobe_n,
  input  wire logic       column_strobe_n,
  input  wire logic       mask_write_n,
  input  wire logic       xfer_oe_n,
  input  wire logic [7:0] addr_in,
  input  wire logic [3:0] dq_ctl,
  input  wire logic       dq_ctl_oe,
  output logic      [3:0] dq_w,
  // Serial port
  input  wire logic       serial_shift_clk,
  input  wire logic       serial_enable_n,
  input  wire logic [3:0] sd_ctl,
  input  wire logic       sd_ctl_oe,
  output logic      [3:0] sd_w
);
  logic [3:0] mem [0:65535];
  logic [3:0] serial_buffer [0:255];
  logic [7:0] row, col, sptr, rcnt;
  logic [3:0] mask, sd_q, dq_last, sd_last;
  logic       xfer, rd_xfer, cbr, mask_on, dir_in, dq_oe, sd_oe;
  initial {xfer, rd_xfer, cbr, dir_in, sptr, rcnt, col, dq_last, sd_last} = 36'h000000000;
  // A released line shows the inverse of its last level, so stale data never reads as valid.
  assign dq_oe = !row_strobe_n && !column_strobe_n && !xfer_oe_n && mask_write_n && !xfer && !cbr;
  assign sd_oe = !dir_in && !serial_enable_n;
  assign dq_w  = dq_ctl_oe ? dq_ctl : dq_oe ? mem[{row, col}] : ~dq_last;
  assign sd_w  = sd_ctl_oe ? sd_ctl : sd_oe ? sd_q : ~sd_last;
  always @(dq_w) if (dq_ctl_oe || dq_oe) dq_last = dq_w;
  always @(sd_w) if (sd_ctl_oe || sd_oe) sd_last = sd_w;
  always @(negedge row_strobe_n) begin
    row     = addr_in;
    cbr     = !column_strobe_n;
    xfer    = !xfer_oe_n && !cbr;
    rd_xfer = xfer && mask_write_n;
    mask_on = !mask_write_n && !xfer;
    mask    = dq_w;
    if (cbr) rcnt = rcnt + 8'h01;
    if (xfer) dir_in = !mask_write_n;
    if (xfer && !mask_write_n && !serial_enable_n)
      for (int i = 0; i < 256; i++) mem[{row, 8'(i)}] = serial_buffer[i];
  end
  always @(posedge row_strobe_n) #1 {xfer, rd_xfer, cbr} = 3'h0;
  always @(negedge column_strobe_n) begin
    if (!row_strobe_n && xfer) sptr = addr_in;
    else if (!row_strobe_n) col = addr_in;
  end
  always @(posedge xfer_oe_n) begin
    if (rd_xfer) for (int i = 0; i < 256; i++) serial_buffer[i] = mem[{row, 8'(i)}];
  end
  always @(negedge column_strobe_n or negedge mask_write_n) begin
    #1;
    if (!row_strobe_n && !column_strobe_n && !mask_write_n && !xfer && !cbr)
      mem[{row, col}] = mask_on ? (mem[{row, col}] & ~mask) | (dq_w & mask) : dq_w;
  end
  always @(posedge serial_shift_clk) begin
    if (dir_in && !serial_enable_n) serial_buffer[sptr] = sd_w;
    sd_q <= #40 serial_buffer[sptr];
    sptr = sptr + 8'h01;
  end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic       sys_clk, rst_b, cmd_valid, cmd_mask_en, stream_en, out_ready, ser_in_valid;
  logic       cmd_ready, rd_valid, out_valid, ser_in_ready, serial_is_input, out_chk;
  logic       row_strobe_n, column_strobe_n, mask_write_n, xfer_oe_n, mask_dq_oe;
  logic       serial_shift_clk, serial_enable_n, serial_data_oe;
  logic [2:0] cmd_op;
  logic [7:0] cmd_row, cmd_col, addr_in;
  logic [3:0] cmd_data, cmd_mask, ser_in_data, rd_data, out_data;
  logic [3:0] mask_dq_i, mask_dq_o, serial_data_i, serial_data_o;
  logic [3:0] sam_ref [0:255];
  logic [3:0] arr_ref [0:7];
  logic [3:0] rd_q [$];
  logic [3:0] out_q [$];
  int         mismatches, n_tests, cycles, got;
  vdc_host dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_row(cmd_row), .cmd_col(cmd_col), .cmd_data(cmd_data),
    .cmd_mask_en(cmd_mask_en), .cmd_mask(cmd_mask), .rd_valid(rd_valid), .rd_data(rd_data),
    .stream_en(stream_en), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .ser_in_valid(ser_in_valid), .ser_in_data(ser_in_data), .ser_in_ready(ser_in_ready),
    .serial_is_input(serial_is_input), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .mask_write_n(mask_write_n), .xfer_oe_n(xfer_oe_n),
    .addr_in(addr_in), .mask_dq_i(mask_dq_i), .mask_dq_o(mask_dq_o), .mask_dq_oe(mask_dq_oe),
    .serial_shift_clk(serial_shift_clk), .serial_enable_n(serial_enable_n),
    .serial_data_i(serial_data_i), .serial_data_o(serial_data_o),
    .serial_data_oe(serial_data_oe));
  vdc_dev_model model (
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n), .mask_write_n(mask_write_n),
    .xfer_oe_n(xfer_oe_n), .addr_in(addr_in), .dq_ctl(mask_dq_o), .dq_ctl_oe(mask_dq_oe),
    .dq_w(mask_dq_i), .serial_shift_clk(serial_shift_clk), .serial_enable_n(serial_enable_n),
    .sd_ctl(serial_data_o), .sd_ctl_oe(serial_data_oe), .sd_w(serial_data_i));
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_word(input logic [3:0] exp, input logic [3:0] act);
    n_tests++;
    if (act !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  // Commands wait out refresh and busy periods on cmd_ready.
  task automatic cmd(input logic [2:0] op, input logic [7:0] r, c, input logic [3:0] d, m,
                     input logic me);
    @(posedge sys_clk);
    #1;
    {cmd_op, cmd_row, cmd_col, cmd_data, cmd_mask, cmd_mask_en} = {op, r, c, d, m, me};
    cmd_valid = 1'b1;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
  endtask
  task automatic idle;
    repeat (2) @(posedge sys_clk);
    while (cmd_ready !== 1'b1) @(posedge sys_clk);
    #1;
  endtask
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) chk_word(rd_q.size() ? rd_q.pop_front() : 4'hx, rd_data);
    if (out_chk && out_valid === 1'b1 && out_ready === 1'b1) begin
      chk_word(out_q.size() ? out_q.pop_front() : 4'hx, out_data);
      got++;
    end
    cycles++;
    if (cycles > 10000) begin
      mismatches++;
      end_sim;
    end
  end
  initial begin
    logic [3:0] d, m;
    void'($urandom(64));
    {mismatches, n_tests, cycles, got} = {32'h0, 32'h0, 32'h0, 32'h0};
    {rst_b, cmd_valid, cmd_mask_en, stream_en, ser_in_valid, out_chk, out_ready} = 7'h01;
    {cmd_op, cmd_row, cmd_col, cmd_data, cmd_mask, ser_in_data} = 31'h00000000;
    for (int i = 0; i < 256; i++) sam_ref[i] = 4'($urandom);
    repeat (5) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      arr_ref[i] = 4'($urandom);
      cmd(3'h1, 8'h10, 8'(i), arr_ref[i], 4'h0, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      d = 4'($urandom);
      m = (i == 0) ? 4'h0 : (i == 7) ? 4'hf : 4'($urandom);
      cmd(3'h1, 8'h10, 8'(i), d, m, 1'b1);
      arr_ref[i] = (arr_ref[i] & ~m) | (d & m);
    end
    for (int i = 0; i < 8; i++) begin
      rd_q.push_back(arr_ref[i]);
      cmd(3'h0, 8'h10, 8'(i), 4'h0, 4'h0, 1'b0);
    end
    ser_in_valid = 1'b1;
    cmd(3'h4, 8'h10, 8'h00, 4'h0, 4'h0, 1'b0);
    for (int i = 0; i < 256; i++) begin
      ser_in_data = sam_ref[i];
      do @(posedge sys_clk); while (ser_in_ready !== 1'b1);
      #1;
    end
    chk_word(4'h1, {3'h0, serial_is_input});
    ser_in_valid = 1'b0;
    cmd(3'h3, 8'h20, 8'h00, 4'h0, 4'h0, 1'b0);
    rd_q.push_back(arr_ref[0]);
    cmd(3'h0, 8'h10, 8'h00, 4'h0, 4'h0, 1'b0);
    for (int i = 0; i < 256; i += 51) begin
      rd_q.push_back(sam_ref[i]);
      cmd(3'h0, 8'h20, 8'(i), 4'h0, 4'h0, 1'b0);
    end
    for (int i = 0; i < 96; i++) out_q.push_back(sam_ref[i + 2]);
    {out_chk, stream_en, out_ready} = 3'h6;
    cmd(3'h2, 8'h20, 8'h00, 4'h0, 4'h0, 1'b0);
    idle;
    chk_word(4'h0, {3'h0, serial_is_input});
    // The buffer fills and refuses while the drain side stalls, then drains at random pace.
    repeat (200) @(posedge sys_clk);
    while (got < 40) begin
      @(posedge sys_clk);
      #1 out_ready = 1'($urandom);
    end
    @(posedge sys_clk);
    #1 {stream_en, out_ready} = 2'h1;
    repeat (300) @(posedge sys_clk);
    #1 {out_chk, stream_en} = 2'h1;
    cmd(3'h5, 8'h10, 8'h00, 4'h0, 4'h0, 1'b0);
    idle;
    chk_word(4'h0, {3'h0, serial_is_input});
    repeat (700) @(posedge sys_clk);
    end_sim;
  end
endmodule
